// [core/adccal_pkg.sv]
package adccal_pkg;

   // printed offsets are register indices; byte address is four times
   localparam int ADCCAL_IDX_OFS_HI  = 'h0A;
   localparam int ADCCAL_IDX_OFS_LO  = 'h0B;
   localparam int ADCCAL_IDX_GAIN_HI = 'h0C;
   localparam int ADCCAL_IDX_GAIN_LO = 'h0D;
   localparam int ADCCAL_IDX_CH1_CHANNEL_CONFIG = 'h0E;
   localparam int ADCCAL_IDX_DC_SET  = 'h08;

   localparam int ADCCAL_AW = 8;
   localparam logic [ADCCAL_AW-1:0] ADCCAL_ADDR_OFS_HI  = 8'h28;
   localparam logic [ADCCAL_AW-1:0] ADCCAL_ADDR_OFS_LO  = 8'h2C;
   localparam logic [ADCCAL_AW-1:0] ADCCAL_ADDR_GAIN_HI = 8'h30;
   localparam logic [ADCCAL_AW-1:0] ADCCAL_ADDR_GAIN_LO = 8'h34;
   localparam logic [ADCCAL_AW-1:0] ADCCAL_ADDR_CH1_CHANNEL_CONFIG = 8'h38;
   localparam logic [ADCCAL_AW-1:0] ADCCAL_ADDR_DC_SET  = 8'h20;

   localparam logic [15:0] ADCCAL_RST_OFS_HI  = 16'h0000;
   localparam logic [7:0]  ADCCAL_RST_OFS_LO  = 8'h00;
   localparam logic [15:0] ADCCAL_RST_GAIN_HI = 16'h8000;
   localparam logic [7:0]  ADCCAL_RST_GAIN_LO = 8'h00;
   localparam logic [9:0]  ADCCAL_RST_PHASE   = 10'h000;
   localparam logic [3:0]  ADCCAL_RST_DC_SET  = 4'h0;

   // field positions
   localparam int ADCCAL_LOBYTE_LSB = 8;
   localparam int ADCCAL_PHASE_LSB  = 6;
   localparam int ADCCAL_BYP_BIT    = 2;
   localparam int ADCCAL_SRC_LSB    = 0;
   localparam int ADCCAL_DC_LSB     = 0;

   // gain word has its unity bit at position 23
   localparam int ADCCAL_GAIN_FRAC = 23;

   typedef enum logic [1:0] {
      ADCCAL_SRC_PINS  = 2'b00,
      ADCCAL_SRC_SHORT = 2'b01,
      ADCCAL_SRC_TPOS  = 2'b10,
      ADCCAL_SRC_TNEG  = 2'b11
   } adccal_src_t;

   typedef struct packed {
      logic [ADCCAL_AW-1:0] paddr;
      logic                 psel;
      logic                 penable;
      logic                 pwrite;
      logic [31:0]          pwdata;
   } adccal_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } adccal_apb_rsp_t;

   typedef struct packed {
      logic signed [23:0] offset_word;
      logic [23:0]        gain_word;
      logic signed [9:0]  ch1_phase_delay;
      logic               ch1_dc_filter_bypass;
      adccal_src_t        ch1_input_source;
      logic [3:0]         shared_dc_filter_setting;
      logic               ch1_dc_filter_on;
   } adccal_cfg_t;

endpackage

// [core/adccal_corr.sv]
`timescale 1ns/1ps
// ch0 correction: (raw - offset) * gain / 2^23, saturated to 24 bits
module adccal_corr
   import adccal_pkg::*;
#(
   parameter int DW = 24
) (
   // clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  clk_en,
   // correction words
   input  wire logic signed [DW-1:0]  offset_word,
   input  wire logic [DW-1:0]         gain_word,
   // sample stream
   input  wire logic                  raw_valid,
   input  wire logic signed [DW-1:0]  raw_data,
   output logic                       cor_valid,
   output logic signed [DW-1:0]       cor_data
);
   import adccal_pkg::*;

   typedef struct packed {
      logic              vld;
      logic [DW-1:0]     dat;
   } adccal_corr_st_t;

   localparam logic signed [2*DW+1:0] MAXV = (2*DW+2)'((1 <<< (DW-1)) - 1);
   localparam logic signed [2*DW+1:0] MINV = -(2*DW+2)'(1 <<< (DW-1));

   adccal_corr_st_t st_ff, nxt_st;
   logic signed [DW:0]      diff;
   logic signed [2*DW+1:0]  prod;
   logic signed [2*DW+1:0]  scl;

   always_comb begin
      nxt_st = st_ff;
      // one extra bit so the subtraction cannot wrap
      diff = (DW+1)'(raw_data) - (DW+1)'(offset_word);
      prod = (2*DW+2)'(diff) * $signed({2'b00, gain_word});
      scl  = prod >>> ADCCAL_GAIN_FRAC;
      nxt_st.vld = raw_valid;
      if (raw_valid) begin
         if (scl > MAXV)
            nxt_st.dat = MAXV[DW-1:0];
         else if (scl < MINV)
            nxt_st.dat = MINV[DW-1:0];
         else
            nxt_st.dat = scl[DW-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         st_ff <= '0;
      else if (clk_en)
         st_ff <= nxt_st;
   end

   assign cor_valid = st_ff.vld;
   assign cor_data  = st_ff.dat;
endmodule

// [core/adccal_regs.sv]
// The APB register port was left to the implementer.
`timescale 1ns/1ps
// Function
// - offset high register holds offset bits 23:8 in all 16 bits, RW.
// - offset low register holds offset bits 7:0 in 15:8; 7:0 read zero.
// - the 24-bit offset word is signed two's complement.
// - both offset registers reset to zero.
// - gain high register holds gain bits 23:8 in all 16 bits, RW.
// - gain low register holds gain bits 7:0 in 15:8; 7:0 read zero.
// - the 24-bit gain word is unsigned, range 0 to just under 2.
// - gain high resets to 8000h (unity), gain low resets to zero.
// - ch1 config bits 15:6 are a signed phase delay resetting to zero.
// - ch1 bypass bit clear follows the shared filter, set turns it off.
// - ch1 source 0 selects the own pin pair, 1 shorts the inputs.
// - ch1 source 2 is positive test signal, 3 negative test signal.
// - shared 4-bit filter setting governs every channel not bypassed; here it only drives ch1 filter on, ch0 has no filter.
module adccal_regs
   import adccal_pkg::*;
#(
   parameter int DW = 24
) (
   // apb clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  clk_en,
   // apb slave
   input  wire adccal_pkg::adccal_apb_req_t apb_req,
   output adccal_pkg::adccal_apb_rsp_t      apb_rsp,
   // decoded configuration
   output adccal_pkg::adccal_cfg_t          cfg,
   // ch1 analog select strobes, one hot
   output logic                       ch1_sel_pins,
   output logic                       ch1_sel_short,
   output logic                       ch1_sel_test_pos,
   output logic                       ch1_sel_test_neg,
   // ch0 sample stream
   input  wire logic                  raw_valid,
   input  wire logic signed [DW-1:0]  raw_data,
   output logic                       cor_valid,
   output logic signed [DW-1:0]       cor_data
);
   import adccal_pkg::*;

   typedef struct packed {
      logic [15:0]  ofs_hi;
      logic [7:0]   ofs_lo;
      logic [15:0]  gain_hi;
      logic [7:0]   gain_lo;
      logic [9:0]   phase;
      logic         byp;
      adccal_src_t  src;
      logic [3:0]   dc_set;
      logic [31:0]  rdata;
      logic         slverr;
   } adccal_st_t;

   adccal_st_t st_ff, nxt_st;

   function automatic logic addr_hit(input logic [ADCCAL_AW-1:0] a);
      addr_hit = (a == ADCCAL_ADDR_OFS_HI) || (a == ADCCAL_ADDR_OFS_LO) ||
                 (a == ADCCAL_ADDR_GAIN_HI) || (a == ADCCAL_ADDR_GAIN_LO) ||
                 (a == ADCCAL_ADDR_CH1_CHANNEL_CONFIG) || (a == ADCCAL_ADDR_DC_SET);
   endfunction

   function automatic logic [15:0] read_word(input adccal_st_t s,
                                             input logic [ADCCAL_AW-1:0] a);
      read_word = 16'h0000;
      case (a)
         ADCCAL_ADDR_OFS_HI:  read_word = s.ofs_hi;
         ADCCAL_ADDR_OFS_LO:  read_word = {s.ofs_lo, 8'h00};
         ADCCAL_ADDR_GAIN_HI: read_word = s.gain_hi;
         ADCCAL_ADDR_GAIN_LO: read_word = {s.gain_lo, 8'h00};
         ADCCAL_ADDR_CH1_CHANNEL_CONFIG:
            read_word = {s.phase, 3'b000, s.byp, s.src};
         ADCCAL_ADDR_DC_SET:  read_word = {12'h000, s.dc_set};
         default:             read_word = 16'h0000;
      endcase
   endfunction

   logic access;
   logic setup;
   logic wr;
   logic [15:0] wd;

   // zero wait states: pready stays high, request completes in access phase
   assign setup  = apb_req.psel && !apb_req.penable;
   assign access = apb_req.psel && apb_req.penable;
   assign wr     = access && apb_req.pwrite && addr_hit(apb_req.paddr);
   assign wd     = apb_req.pwdata[15:0];

   always_comb begin
      nxt_st = st_ff;
      if (wr) begin
         case (apb_req.paddr)
            ADCCAL_ADDR_OFS_HI:  nxt_st.ofs_hi = wd;
            ADCCAL_ADDR_OFS_LO:
               nxt_st.ofs_lo = wd[ADCCAL_LOBYTE_LSB +: 8];
            ADCCAL_ADDR_GAIN_HI: nxt_st.gain_hi = wd;
            ADCCAL_ADDR_GAIN_LO:
               nxt_st.gain_lo = wd[ADCCAL_LOBYTE_LSB +: 8];
            ADCCAL_ADDR_CH1_CHANNEL_CONFIG: begin
               nxt_st.phase = wd[ADCCAL_PHASE_LSB +: 10];
               nxt_st.byp   = wd[ADCCAL_BYP_BIT];
               nxt_st.src   = adccal_src_t'(wd[ADCCAL_SRC_LSB +: 2]);
            end
            ADCCAL_ADDR_DC_SET:
               nxt_st.dc_set = wd[ADCCAL_DC_LSB +: 4];
            default: nxt_st.dc_set = st_ff.dc_set;
         endcase
      end
      // word captured in setup so prdata comes from a flop, still zero wait
      nxt_st.rdata  = 32'h0000_0000;
      nxt_st.slverr = 1'b0;
      if (setup) begin
         nxt_st.slverr = !addr_hit(apb_req.paddr);
         if (!apb_req.pwrite)
            nxt_st.rdata = {16'h0000, read_word(st_ff, apb_req.paddr)};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff.ofs_hi  <= ADCCAL_RST_OFS_HI;
         st_ff.ofs_lo  <= ADCCAL_RST_OFS_LO;
         st_ff.gain_hi <= ADCCAL_RST_GAIN_HI;
         st_ff.gain_lo <= ADCCAL_RST_GAIN_LO;
         st_ff.phase   <= ADCCAL_RST_PHASE;
         st_ff.byp     <= 1'b0;
         st_ff.src     <= ADCCAL_SRC_PINS;
         st_ff.dc_set  <= ADCCAL_RST_DC_SET;
         st_ff.rdata   <= 32'h0000_0000;
         st_ff.slverr  <= 1'b0;
      end else if (clk_en) begin
         st_ff <= nxt_st;
      end
   end

   // prdata stands only in the access phase; cleared again right after it
   always_comb begin
      apb_rsp.pready  = 1'b1;
      apb_rsp.pslverr = access && st_ff.slverr;
      apb_rsp.prdata  = st_ff.rdata;
   end

   always_comb begin
      cfg.offset_word = {st_ff.ofs_hi, st_ff.ofs_lo};
      cfg.gain_word   = {st_ff.gain_hi, st_ff.gain_lo};
      cfg.ch1_phase_delay = st_ff.phase;
      cfg.ch1_dc_filter_bypass = st_ff.byp;
      cfg.ch1_input_source = st_ff.src;
      cfg.shared_dc_filter_setting = st_ff.dc_set;
      // filter runs on the shared setting unless bypassed
      cfg.ch1_dc_filter_on = !st_ff.byp && (st_ff.dc_set != 4'h0);
   end

   always_comb begin
      ch1_sel_pins     = (st_ff.src == ADCCAL_SRC_PINS);
      ch1_sel_short    = (st_ff.src == ADCCAL_SRC_SHORT);
      ch1_sel_test_pos = (st_ff.src == ADCCAL_SRC_TPOS);
      ch1_sel_test_neg = (st_ff.src == ADCCAL_SRC_TNEG);
   end

   adccal_corr #(.DW(DW)) u_corr (
      .pclk        (pclk),
      .presetn     (presetn),
      .clk_en      (clk_en),
      .offset_word (cfg.offset_word),
      .gain_word   (cfg.gain_word),
      .raw_valid   (raw_valid),
      .raw_data    (raw_data),
      .cor_valid   (cor_valid),
      .cor_data    (cor_data)
   );

   property p_ofs_lo_res;
      @(posedge pclk) disable iff (!presetn)
      (access && !apb_req.pwrite && apb_req.paddr == ADCCAL_ADDR_OFS_LO)
         |-> apb_rsp.prdata[7:0] == 8'h00;
   endproperty
   a_ofs_lo_res: assert property (p_ofs_lo_res)
      else $error("offset low reserved byte not zero");

   property p_gain_lo_res;
      @(posedge pclk) disable iff (!presetn)
      (access && !apb_req.pwrite && apb_req.paddr == ADCCAL_ADDR_GAIN_LO)
         |-> apb_rsp.prdata[15:0] == {st_ff.gain_lo, 8'h00};
   endproperty
   a_gain_lo_res: assert property (p_gain_lo_res)
      else $error("gain low read wrong");

   property p_ofs_hi_wr;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && wr && apb_req.paddr == ADCCAL_ADDR_OFS_HI)
         |=> st_ff.ofs_hi == $past(apb_req.pwdata[15:0]);
   endproperty
   a_ofs_hi_wr: assert property (p_ofs_hi_wr)
      else $error("offset high write lost");

   property p_gain_hi_wr;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && wr && apb_req.paddr == ADCCAL_ADDR_GAIN_HI)
         |=> cfg.gain_word[23:8] == $past(apb_req.pwdata[15:0]);
   endproperty
   a_gain_hi_wr: assert property (p_gain_hi_wr)
      else $error("gain high write lost");

   property p_cfg_res;
      @(posedge pclk) disable iff (!presetn)
      (access && !apb_req.pwrite && apb_req.paddr == ADCCAL_ADDR_CH1_CHANNEL_CONFIG)
         |-> apb_rsp.prdata[5:3] == 3'b000;
   endproperty
   a_cfg_res: assert property (p_cfg_res)
      else $error("config reserved bits not zero");

   property p_bypass;
      @(posedge pclk) disable iff (!presetn)
      cfg.ch1_dc_filter_bypass |-> !cfg.ch1_dc_filter_on;
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("filter on while bypassed");

   property p_shared;
      @(posedge pclk) disable iff (!presetn)
      !cfg.ch1_dc_filter_bypass
         |-> cfg.ch1_dc_filter_on == (cfg.shared_dc_filter_setting != 4'h0);
   endproperty
   a_shared: assert property (p_shared)
      else $error("filter not following shared setting");

   property p_src;
      @(posedge pclk) disable iff (!presetn)
      (cfg.ch1_input_source == ADCCAL_SRC_TNEG) |-> ch1_sel_test_neg &&
         !ch1_sel_pins && !ch1_sel_short && !ch1_sel_test_pos;
   endproperty
   a_src: assert property (p_src)
      else $error("source select not decoded");

   property p_short;
      @(posedge pclk) disable iff (!presetn)
      (cfg.ch1_input_source == ADCCAL_SRC_SHORT) |-> ch1_sel_short;
   endproperty
   a_short: assert property (p_short)
      else $error("short select missing");

   property p_ofs_lo_wr;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && wr && apb_req.paddr == ADCCAL_ADDR_OFS_LO)
         |=> cfg.offset_word[7:0] == $past(apb_req.pwdata[15:8]);
   endproperty
   a_ofs_lo_wr: assert property (p_ofs_lo_wr)
      else $error("offset low write lost");

   property p_gain_lo_wr;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && wr && apb_req.paddr == ADCCAL_ADDR_GAIN_LO)
         |=> cfg.gain_word[7:0] == $past(apb_req.pwdata[15:8]);
   endproperty
   a_gain_lo_wr: assert property (p_gain_lo_wr)
      else $error("gain low write lost");

   property p_phase_wr;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && wr && apb_req.paddr == ADCCAL_ADDR_CH1_CHANNEL_CONFIG)
         |=> cfg.ch1_phase_delay == $past(apb_req.pwdata[15:6]);
   endproperty
   a_phase_wr: assert property (p_phase_wr)
      else $error("phase delay write lost");

   property p_byp_wr;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && wr && apb_req.paddr == ADCCAL_ADDR_CH1_CHANNEL_CONFIG)
         |=> cfg.ch1_dc_filter_bypass == $past(apb_req.pwdata[2]);
   endproperty
   a_byp_wr: assert property (p_byp_wr)
      else $error("bypass write lost");

   property p_dc_wr;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && wr && apb_req.paddr == ADCCAL_ADDR_DC_SET)
         |=> cfg.shared_dc_filter_setting == $past(apb_req.pwdata[3:0]);
   endproperty
   a_dc_wr: assert property (p_dc_wr)
      else $error("shared filter setting write lost");

   property p_hold;
      @(posedge pclk) disable iff (!presetn)
      !(clk_en && wr)
         |=> $stable(cfg.offset_word) && $stable(cfg.gain_word);
   endproperty
   a_hold: assert property (p_hold)
      else $error("calibration word changed without a write");

   property p_src_pins;
      @(posedge pclk) disable iff (!presetn)
      (cfg.ch1_input_source == ADCCAL_SRC_PINS)
         |-> ch1_sel_pins && !ch1_sel_test_neg;
   endproperty
   a_src_pins: assert property (p_src_pins)
      else $error("pin pair select missing");

   property p_src_tpos;
      @(posedge pclk) disable iff (!presetn)
      (cfg.ch1_input_source == ADCCAL_SRC_TPOS)
         |-> ch1_sel_test_pos && !ch1_sel_short;
   endproperty
   a_src_tpos: assert property (p_src_tpos)
      else $error("positive test select missing");

   property p_rd_upper;
      @(posedge pclk) disable iff (!presetn)
      (access && !apb_req.pwrite)
         |-> apb_rsp.prdata[31:16] == 16'h0000;
   endproperty
   a_rd_upper: assert property (p_rd_upper)
      else $error("read data upper half not zero");
endmodule

// [testbench/tb_adc_channel_cal_cfg_regs.sv]
`timescale 1ns/1ps
module tb_adc_channel_cal_cfg_regs;
   import adccal_pkg::*;
   // run needs well under 1000 cycles
   localparam int TMO = 3000;
   logic            pclk;
   logic            presetn;
   logic            clk_en;
   adccal_apb_req_t apb_req;
   adccal_apb_rsp_t apb_rsp;
   adccal_cfg_t     cfg;
   logic            ch1_sel_pins;
   logic            ch1_sel_short;
   logic            ch1_sel_test_pos;
   logic            ch1_sel_test_neg;
   logic            raw_valid;
   logic [23:0]     raw_data;
   logic            cor_valid;
   logic [23:0]     cor_data;
   logic [31:0]     rd;
   logic            err;
   int              mismatches = 0;
   int              num_checks = 0;
   int              cycles = 0;

   adccal_regs #(.DW(24)) adccal_regs_inst (
      .pclk             (pclk),
      .presetn          (presetn),
      .clk_en           (clk_en),
      .apb_req          (apb_req),
      .apb_rsp          (apb_rsp),
      .cfg              (cfg),
      .ch1_sel_pins     (ch1_sel_pins),
      .ch1_sel_short    (ch1_sel_short),
      .ch1_sel_test_pos (ch1_sel_test_pos),
      .ch1_sel_test_neg (ch1_sel_test_neg),
      .raw_valid        (raw_valid),
      .raw_data         (raw_data),
      .cor_valid        (cor_valid),
      .cor_data         (cor_data)
   );

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == TMO) begin
         mismatches++;
         finish_test();
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // entered just after a rising edge; holds the request until pready
   task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      apb_req.paddr <= a;
      apb_req.psel <= 1'b1;
      apb_req.penable <= 1'b0;
      apb_req.pwrite <= w;
      apb_req.pwdata <= d;
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      // no local limit: only the bench timeout ends a stuck wait
      do begin
         @(posedge pclk);
      end while (apb_rsp.pready !== 1'b1);
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
      @(posedge pclk);
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask

   task rdc(input logic [7:0] a, input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0000_0000);
      chk(rd, exp);
   endtask

   // one sample in, corrected sample expected a cycle later
   task samp(input logic [23:0] raw, input logic [23:0] exp);
      raw_valid <= 1'b1;
      raw_data <= raw;
      @(posedge pclk);
      raw_valid <= 1'b0;
      // result launched at this edge, looked at once it has settled
      @(negedge pclk);
      chk({31'h0, cor_valid}, 32'h1);
      chk({8'h00, cor_data}, {8'h00, exp});
      @(posedge pclk);
   endtask

   initial begin
      presetn = 1'b0;
      clk_en = 1'b1;
      apb_req = '0;
      raw_valid = 1'b0;
      raw_data = 24'h000000;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(ADCCAL_ADDR_OFS_HI, 32'h0000_0000);
      chk({31'h0, err}, 32'h0);
      rdc(ADCCAL_ADDR_OFS_LO, 32'h0000_0000);
      rdc(ADCCAL_ADDR_GAIN_HI, 32'h0000_8000);
      rdc(ADCCAL_ADDR_GAIN_LO, 32'h0000_0000);
      rdc(ADCCAL_ADDR_CH1_CHANNEL_CONFIG, 32'h0000_0000);
      chk({8'h00, cfg.gain_word}, 32'h0080_0000);
      chk({31'h0, ch1_sel_pins}, 32'h1);
      chk({31'h0, cfg.ch1_dc_filter_on}, 32'h0);
      // upper half of pwdata and reserved bits must not stick
      wr(ADCCAL_ADDR_OFS_HI, 32'hFFFF_A5C3);
      chk({31'h0, err}, 32'h0);
      wr(ADCCAL_ADDR_OFS_LO, 32'hFFFF_FFFF);
      rdc(ADCCAL_ADDR_OFS_HI, 32'h0000_A5C3);
      rdc(ADCCAL_ADDR_OFS_LO, 32'h0000_FF00);
      chk({8'h00, cfg.offset_word}, 32'h00A5_C3FF);
      chk({31'h0, $signed(cfg.offset_word) < 0}, 32'h1);
      wr(ADCCAL_ADDR_GAIN_HI, 32'h0001_FFFF);
      wr(ADCCAL_ADDR_GAIN_LO, 32'h0000_ABCD);
      rdc(ADCCAL_ADDR_GAIN_HI, 32'h0000_FFFF);
      rdc(ADCCAL_ADDR_GAIN_LO, 32'h0000_AB00);
      chk({8'h00, cfg.gain_word}, 32'h00FF_FFAB);
      wr(ADCCAL_ADDR_CH1_CHANNEL_CONFIG, 32'h0000_FFFF);
      rdc(ADCCAL_ADDR_CH1_CHANNEL_CONFIG, 32'h0000_FFC7);
      chk({22'h0, cfg.ch1_phase_delay}, 32'h3FF);
      chk({31'h0, cfg.ch1_dc_filter_bypass}, 32'h1);
      chk({30'h0, cfg.ch1_input_source}, 32'h3);
      wr(ADCCAL_ADDR_DC_SET, 32'hFFFF_FFF5);
      rdc(ADCCAL_ADDR_DC_SET, 32'h0000_0005);
      chk({28'h0, cfg.shared_dc_filter_setting}, 32'h5);
      chk({31'h0, cfg.ch1_dc_filter_on}, 32'h0);
      // every source code, phase at its most negative value
      for (int s = 0; s < 4; s++) begin
         wr(ADCCAL_ADDR_CH1_CHANNEL_CONFIG, 32'h0000_8000 | s);
         rdc(ADCCAL_ADDR_CH1_CHANNEL_CONFIG, 32'h0000_8000 | s);
         chk({28'h0, ch1_sel_test_neg, ch1_sel_test_pos, ch1_sel_short,
              ch1_sel_pins}, 32'h1 << s);
         chk({30'h0, cfg.ch1_input_source}, s);
         chk({31'h0, cfg.ch1_dc_filter_bypass}, 32'h0);
         chk({31'h0, cfg.ch1_dc_filter_on}, 32'h1);
         chk({22'h0, cfg.ch1_phase_delay}, 32'h200);
      end
      wr(8'h3C, 32'h0000_FFFF);
      chk({31'h0, err}, 32'h1);
      rdc(8'h3C, 32'h0000_0000);
      chk({31'h0, err}, 32'h1);
      // frozen state: the write is dropped though pready answers
      clk_en <= 1'b0;
      wr(ADCCAL_ADDR_OFS_HI, 32'h0000_1234);
      clk_en <= 1'b1;
      rdc(ADCCAL_ADDR_OFS_HI, 32'h0000_A5C3);
      wr(ADCCAL_ADDR_OFS_HI, 32'h0000_0001);
      wr(ADCCAL_ADDR_OFS_LO, 32'h0000_0000);
      wr(ADCCAL_ADDR_GAIN_HI, 32'h0000_8000);
      wr(ADCCAL_ADDR_GAIN_LO, 32'h0000_0000);
      samp(24'h001000, 24'h000F00);
      samp(24'h800000, 24'h800000);
      wr(ADCCAL_ADDR_GAIN_HI, 32'h0000_4000);
      samp(24'h001000, 24'h000780);
      wr(ADCCAL_ADDR_GAIN_HI, 32'h0000_8000);
      wr(ADCCAL_ADDR_OFS_HI, 32'h0000_FFFF);
      samp(24'h7FFFFF, 24'h7FFFFF);
      // second reset in mid-run
      presetn <= 1'b0;
      @(posedge pclk);
      chk({8'h00, cfg.gain_word}, 32'h0080_0000);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(ADCCAL_ADDR_OFS_HI, 32'h0000_0000);
      rdc(ADCCAL_ADDR_GAIN_HI, 32'h0000_8000);
      rdc(ADCCAL_ADDR_CH1_CHANNEL_CONFIG, 32'h0000_0000);
      rdc(ADCCAL_ADDR_DC_SET, 32'h0000_0000);
      finish_test();
   end
endmodule
